// ===== core/ftdmo_regs.svh
// Register offsets, field positions and counts of the flexible TDM output slot mapper
`ifndef FTDMO_REGS_SVH
`define FTDMO_REGS_SVH

// Address window of the 64 slot registers
`define FTDMO_BASE 16'hf380
`define FTDMO_LAST 16'hf3bf

// Register geometry and reset value
`define FTDMO_RESET 8'h00
`define FTDMO_RSVD 8'h00
`define FTDMO_RD_IDLE 16'h0000

// Bit position within the frame: slot in the high bits, bit in slot low
`define FTDMO_CNT_W 8
`define FTDMO_CNT_ZERO 8'h00
`define FTDMO_CNT_ONE 8'h01
`define FTDMO_BIT_W 3
`define FTDMO_PIN_B_SLOT 1'b1

// Slot and bit fields of the frame position, and the first bit of a slot either way round
`define FTDMO_SLOT_HI 7
`define FTDMO_SLOT_LO 3
`define FTDMO_BIT_HI 2
`define FTDMO_BIT_MSB 3'b111
`define FTDMO_BIT_LSB 3'b000

`endif

// ===== core/ftdmo_pkg.sv
// Types shared by the flexible TDM output slot mapper
package ftdmo_pkg;

    // One slot register, low byte; the reserved high byte is not stored
    typedef struct packed {
        logic en;
        logic rev;
        logic grp;
        logic [2:0] pos;
        logic [1:0] sel;
    } ftdmo_slot_t;

    // Driven level and active-low output enable of one serial data pin
    typedef struct packed {
        logic d;
        logic oe_n;
    } ftdmo_pin_t;

    // One register access request
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } ftdmo_req_t;

endpackage

// ===== core/ftdmo_mapper.sv
// Flexible TDM output slot mapper: slot registers and the two serial data pins
`timescale 1ns/1ps
`include "ftdmo_regs.svh"

module ftdmo_mapper #(
    parameter int SLOTS = 64,
    parameter int CHANS = 16
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire ftdmo_pkg::ftdmo_req_t REG_REQ,
    output ftdmo_pkg::ftdmo_pin_t FLEX_DATA_OUT_A,
    output ftdmo_pkg::ftdmo_pin_t FLEX_DATA_OUT_B,
    output logic [15:0] REG_RDATA,
    input wire logic FRAME_START,
    input wire logic BIT_TICK,
    input wire logic IDLE_HIGH_Z_A,
    input wire logic IDLE_HIGH_Z_B,
    input wire logic [CHANS-1:0][31:0] CHAN_DATA
);
    import ftdmo_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte picked from the channel word by group, position and byte select
    function automatic logic [7:0] pick_byte(
        input ftdmo_slot_t c,
        input logic [CHANS-1:0][31:0] ch
    );
        logic [31:0] w;
        w = ch[{c.grp, c.pos}];
        return w[{~c.sel, `FTDMO_BIT_LSB} +: 8];
    endfunction

    // Pin level and enable for one bit time of one slot
    function automatic ftdmo_pin_t slot_pin(
        input ftdmo_slot_t c,
        input logic [CHANS-1:0][31:0] ch,
        input logic [`FTDMO_BIT_W-1:0] b,
        input logic hz
    );
        logic [7:0] byt;
        ftdmo_pin_t p;
        byt = pick_byte(c, ch);
        p.d = 1'b0;
        p.oe_n = 1'b0;
        if (c.en) begin
            // Bit 0 of the slot is the MSB unless reversed
            p.d = c.rev ? byt[b] : byt[~b];
        end else if (hz) begin
            p.oe_n = 1'b1;
        end else begin
            p.d = 1'b0;
        end
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register access

    ftdmo_slot_t map_q [SLOTS];
    ftdmo_slot_t map_d [SLOTS];
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic in_range;
    logic [5:0] idx;

    // Only the printed window decodes; anything else is ignored
    // Exact window, so neighbouring control registers never alias onto a slot
    assign in_range = (REG_REQ.addr >= `FTDMO_BASE) && (REG_REQ.addr <= `FTDMO_LAST);
    assign idx = 6'(REG_REQ.addr - `FTDMO_BASE);

    // Next slot table; reserved high byte is dropped on write
    always_comb begin
        map_d = map_q;
        if (REG_REQ.wr && in_range) begin
            map_d[idx] = ftdmo_slot_t'(REG_REQ.wdata[7:0]);
        end
    end

    // Read answer one edge after the request; unmapped reads give zero
    always_comb begin
        rdata_d = rdata_q;
        if (REG_REQ.rd) begin
            rdata_d = in_range ? {`FTDMO_RSVD, map_q[idx]} : `FTDMO_RD_IDLE;
        end
    end

    // Table and read data registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            for (int i = 0; i < SLOTS; i++) begin
                map_q[i] <= ftdmo_slot_t'(`FTDMO_RESET);
            end
            rdata_q <= `FTDMO_RD_IDLE;
        end else begin
            map_q <= map_d;
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Bit position in the frame

    logic [`FTDMO_CNT_W-1:0] cnt_q;
    logic [`FTDMO_CNT_W-1:0] cnt_d;

    // Frame boundary wins over a tick in the same cycle; wraps after slot 31
    // Limitation: a frame longer than 32 slots repeats from slot 0
    always_comb begin
        cnt_d = cnt_q;
        if (FRAME_START) begin
            cnt_d = `FTDMO_CNT_ZERO;
        end else if (BIT_TICK) begin
            cnt_d = cnt_q + `FTDMO_CNT_ONE;
        end
    end

    // Counter register
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cnt_q <= `FTDMO_CNT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial data pins

    ftdmo_slot_t cur_a;
    ftdmo_slot_t cur_b;
    logic [`FTDMO_BIT_W-1:0] bit_d;
    ftdmo_pin_t pin_a_q;
    ftdmo_pin_t pin_a_d;
    ftdmo_pin_t pin_b_q;
    ftdmo_pin_t pin_b_d;

    // Slot for the coming bit time; pin B reads the upper half of the table
    assign cur_a = map_q[{~`FTDMO_PIN_B_SLOT, cnt_d[`FTDMO_SLOT_HI:`FTDMO_SLOT_LO]}];
    assign cur_b = map_q[{`FTDMO_PIN_B_SLOT, cnt_d[`FTDMO_SLOT_HI:`FTDMO_SLOT_LO]}];
    assign bit_d = cnt_d[`FTDMO_BIT_HI:0];

    // Pins follow the counter on the same edge, so no extra bit of lag
    always_comb begin
        pin_a_d = slot_pin(cur_a, CHAN_DATA, bit_d, IDLE_HIGH_Z_A);
        pin_b_d = slot_pin(cur_b, CHAN_DATA, bit_d, IDLE_HIGH_Z_B);
    end

    // Pins released while in reset
    // so a receiver never sees stale slot data across a restart
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pin_a_q <= '{d: 1'b0, oe_n: 1'b1};
            pin_b_q <= '{d: 1'b0, oe_n: 1'b1};
        end else begin
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
        end
    end

    assign FLEX_DATA_OUT_A = pin_a_q;
    assign FLEX_DATA_OUT_B = pin_b_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    // Expected MSB-first bit computed by plain indexing, independent of the function
    // so a slip in either path shows up as a mismatch
    logic exp_a;
    logic exp_b;
    assign exp_a = CHAN_DATA[{cur_a.grp, cur_a.pos}][{~cur_a.sel, ~bit_d}];
    assign exp_b = CHAN_DATA[{cur_b.grp, cur_b.pos}][{~cur_b.sel, ~bit_d}];

    // First bit of the lowest slot of each pin, for the frame boundary checks
    localparam int PIN_B_FIRST = SLOTS / 2;
    ftdmo_slot_t first_a;
    ftdmo_slot_t first_b;
    logic lead_a;
    logic lead_b;
    assign first_a = map_q[0];
    assign first_b = map_q[PIN_B_FIRST];
    assign lead_a = CHAN_DATA[{first_a.grp, first_a.pos}]
        [{~first_a.sel, (first_a.rev ? `FTDMO_BIT_LSB : `FTDMO_BIT_MSB)}];
    assign lead_b = CHAN_DATA[{first_b.grp, first_b.pos}]
        [{~first_b.sel, (first_b.rev ? `FTDMO_BIT_LSB : `FTDMO_BIT_MSB)}];

    sequence s_write;
        REG_REQ.wr && in_range;
    endsequence

    sequence s_read_back;
        REG_REQ.rd && in_range && !REG_REQ.wr;
    endsequence

    // Disabled slot on pin A with idle_high_z set leaves the pin released
    a_pin_hiz_idle: assert property (
        !cur_a.en && IDLE_HIGH_Z_A |=> FLEX_DATA_OUT_A.oe_n)
        else $error("pin A not released in disabled slot");

    // Disabled slot on pin B with idle_high_z clear drives low
    a_pin_low_idle: assert property (
        !cur_b.en && !IDLE_HIGH_Z_B |=> !FLEX_DATA_OUT_B.oe_n && !FLEX_DATA_OUT_B.d)
        else $error("pin B not driven low in disabled slot");

    // Enabled, non-reversed slot on pin A drives its byte MSB first
    a_pin_msb_first: assert property (
        cur_a.en && !cur_a.rev |=> !FLEX_DATA_OUT_A.oe_n && FLEX_DATA_OUT_A.d == $past(exp_a))
        else $error("pin A data bit wrong");

    // Reversed slot on pin B starts from the byte's LSB
    a_pin_reversed: assert property (
        cur_b.en && cur_b.rev |=> FLEX_DATA_OUT_B.d
            == $past(CHAN_DATA[{cur_b.grp, cur_b.pos}][{~cur_b.sel, bit_d}]))
        else $error("pin B reversed bit wrong");

    // Group, channel and byte picks reach pin B
    a_group_pick: assert property (
        cur_b.en && !cur_b.rev |=> FLEX_DATA_OUT_B.d == $past(exp_b))
        else $error("pin B channel or byte wrong");

    // Frame boundary puts the position back at slot 0, bit 0
    a_frame_restart: assert property (
        FRAME_START |=> cnt_q == `FTDMO_CNT_ZERO)
        else $error("frame start did not restart slot count");

    // Each tick without a frame boundary moves one bit on
    a_slot_advance: assert property (
        BIT_TICK && !FRAME_START |=> cnt_q == $past(cnt_q) + `FTDMO_CNT_ONE)
        else $error("slot count did not advance");

    // A write in the window lands in its slot at once
    a_slot_store: assert property (
        s_write |=> map_q[$past(idx)] == ftdmo_slot_t'($past(REG_REQ.wdata[7:0])))
        else $error("slot register not written");

    // Write then read of the same slot returns the written byte
    a_read_back: assert property (
        s_write ##1 s_read_back |=> REG_RDATA[7:0] == $past(REG_REQ.wdata[7:0], 2)
            || $past(idx) != $past(idx, 2))
        else $error("slot register read back wrong");

    // Reserved high byte always reads zero
    a_rsvd_zero: assert property (
        REG_REQ.rd |=> REG_RDATA[15:8] == `FTDMO_RSVD)
        else $error("reserved bits not zero");

    // Pin B opens each frame with slot 32, in the order that slot asks for
    a_pin_split: assert property (
        FRAME_START && first_b.en |=> !FLEX_DATA_OUT_B.oe_n && FLEX_DATA_OUT_B.d == $past(lead_b))
        else $error("pin B not on upper slot half");

    // Pin A opens each frame with slot 0
    a_pin_a_first: assert property (
        FRAME_START && first_a.en |=> !FLEX_DATA_OUT_A.oe_n && FLEX_DATA_OUT_A.d == $past(lead_a))
        else $error("pin A did not open the frame with slot 0");

    // Disabled slot on pin B with idle_high_z set leaves the pin released
    a_pin_b_hiz: assert property (
        !cur_b.en && IDLE_HIGH_Z_B |=> FLEX_DATA_OUT_B.oe_n)
        else $error("pin B not released in disabled slot");

    // Disabled slot on pin A with idle_high_z clear drives low
    a_pin_a_low: assert property (
        !cur_a.en && !IDLE_HIGH_Z_A |=> !FLEX_DATA_OUT_A.oe_n && !FLEX_DATA_OUT_A.d)
        else $error("pin A not driven low in disabled slot");

    // Reversed slot on pin A starts from the byte's LSB
    a_pin_a_rev: assert property (
        cur_a.en && cur_a.rev |=> !FLEX_DATA_OUT_A.oe_n && FLEX_DATA_OUT_A.d
            == $past(CHAN_DATA[{cur_a.grp, cur_a.pos}][{~cur_a.sel, bit_d}]))
        else $error("pin A reversed bit wrong");

    // Enabled slot on pin B always drives
    a_pin_b_drive: assert property (
        cur_b.en |=> !FLEX_DATA_OUT_B.oe_n)
        else $error("pin B released in enabled slot");

    // Reads outside the slot window answer zero
    a_rd_unmapped: assert property (
        REG_REQ.rd && !in_range |=> REG_RDATA == `FTDMO_RD_IDLE)
        else $error("unmapped read not zero");

    // A slot keeps its setting while no write is presented
    a_slot_hold: assert property (
        !REG_REQ.wr |=> map_q[$past(idx)] == $past(map_q[idx]))
        else $error("slot register changed without a write");

    // Read data stands until the next read
    a_rd_hold: assert property (
        !REG_REQ.rd |=> REG_RDATA == $past(REG_RDATA))
        else $error("read data changed without a read");

    // Position holds while neither a tick nor a frame boundary arrives
    a_count_hold: assert property (
        !BIT_TICK && !FRAME_START |=> cnt_q == $past(cnt_q))
        else $error("slot count moved without a tick");

    // Reset clears the table and read data and releases both pins
    a_reset_clear: assert property (disable iff (1'b0)
        RST |=> REG_RDATA == `FTDMO_RD_IDLE && map_q[SLOTS-1] == ftdmo_slot_t'(`FTDMO_RESET)
            && FLEX_DATA_OUT_A.oe_n && FLEX_DATA_OUT_B.oe_n)
        else $error("reset did not clear table and pins");

endmodule

// ===== tb/ftdmo_rx.sv
// Receiver model that samples one serial data pin on each clock edge its sample strobe is set
`timescale 1ns/1ps
module ftdmo_rx
    import ftdmo_pkg::*;
(
    input wire logic clk,
    input wire logic smp,
    input wire ftdmo_pkg::ftdmo_pin_t pin,
    output logic [7:0] data_q,
    output logic [7:0] oe_n_q
);
    // Shift in first bit at the top; enable kept so released bits show up
    always_ff @(posedge clk) begin
        if (smp) begin
            data_q <= {data_q[6:0], pin.d};
            oe_n_q <= {oe_n_q[6:0], pin.oe_n};
        end
    end
endmodule

// ===== tb/ftdmo_mapper_tb.sv
// Self-checking bench for the TDM output slot mapper
`timescale 1ns/1ps
module ftdmo_mapper_tb;
    import ftdmo_pkg::*;
    logic clk, rst, fs, tick, smp, hz_a, hz_b;
    ftdmo_req_t req;
    ftdmo_pin_t pin_a, pin_b;
    logic [15:0] rdata;
    logic [15:0][31:0] cd;
    logic [7:0] rx_a, rx_b, oe_a, oe_b;
    int n_mismatch = 0, num_checks = 0, cycles = 0, i;
    int slots[5] = '{0, 1, 2, 5, 31};
    logic [7:0] cfgs[5] = '{8'h80, 8'hc5, 8'he3, 8'hbe, 8'h5f};

    ftdmo_mapper i_ftdmo_mapper (.CLOCK(clk), .RST(rst), .REG_REQ(req),
        .FLEX_DATA_OUT_A(pin_a), .FLEX_DATA_OUT_B(pin_b), .REG_RDATA(rdata),
        .FRAME_START(fs), .BIT_TICK(tick), .IDLE_HIGH_Z_A(hz_a),
        .IDLE_HIGH_Z_B(hz_b), .CHAN_DATA(cd));
    ftdmo_rx i_ftdmo_rx_a (.clk(clk), .smp(smp), .pin(pin_a), .data_q(rx_a), .oe_n_q(oe_a));
    ftdmo_rx i_ftdmo_rx_b (.clk(clk), .smp(smp), .pin(pin_b), .data_q(rx_b), .oe_n_q(oe_b));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard, run needs about 800 cycles
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task reg_wr(input logic [15:0] a, input logic [15:0] v);
        @(negedge clk);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
        @(negedge clk);
        req = '0;
    endtask
    task reg_rd(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clk);
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(negedge clk);
        req = '0;
        check("read data", exp, rdata);
    endtask
    // Frame start, then back-to-back ticks; receiver samples slot k only
    task run_slot(input int k);
        @(negedge clk);
        fs = 1'b1;
        @(negedge clk);
        fs = 1'b0;
        tick = 1'b1;
        for (int j = 0; j < 8 * k + 8; j++) begin
            smp = (j >= 8 * k);
            @(negedge clk);
        end
        tick = 1'b0;
        smp = 1'b0;
    endtask
    // Byte expected on the wire for one slot setting
    function automatic logic [7:0] exp_byte(input logic [7:0] c);
        logic [7:0] b;
        b = cd[{c[5], c[4:2]}][8 * (3 - c[1:0]) +: 8];
        if (c[6]) b = {<<{b}};
        return c[7] ? b : 8'h00;
    endfunction
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        rst = 1'b1;
        req = '0;
        fs = 1'b0;
        tick = 1'b0;
        smp = 1'b0;
        hz_a = 1'b1;
        hz_b = 1'b0;
        for (i = 0; i < 16; i++) cd[i] = 32'h12345678 + 32'h11111111 * i;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 64; i++) reg_rd(16'hf380 + 16'(i), 16'h0000);
        $display("test reset_values done");
        // Reserved byte dropped, unmapped places ignored
        reg_wr(16'hf3bf, 16'hffa5);
        reg_rd(16'hf3bf, 16'h00a5);
        reg_wr(16'hf3c0, 16'h0081);
        reg_rd(16'hf3c0, 16'h0000);
        reg_rd(16'hf37f, 16'h0000);
        reg_wr(16'hf3bf, 16'h0000);
        // Back to back: write, read next edge, then write and read together
        @(negedge clk);
        req = '{addr: 16'hf385, wr: 1'b1, rd: 1'b0, wdata: 16'h00a7};
        @(negedge clk);
        req = '{addr: 16'hf385, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(negedge clk);
        req = '{addr: 16'hf386, wr: 1'b1, rd: 1'b1, wdata: 16'h0011};
        check("write then read", 16'h00a7, rdata);
        @(negedge clk);
        req = '0;
        check("read beside write", 16'h0000, rdata);
        reg_rd(16'hf386, 16'h0011);
        $display("test register_access done");
        // Same slot index on both pins, pin B with group and order flipped
        for (i = 0; i < 5; i++) begin
            reg_wr(16'hf380 + 16'(slots[i]), {8'h00, cfgs[i]});
            reg_wr(16'hf3a0 + 16'(slots[i]), {8'h00, cfgs[i] ^ 8'h60});
            run_slot(slots[i]);
            if (cfgs[i][7]) check("pin a data", {8'h00, exp_byte(cfgs[i])}, {8'h00, rx_a});
            check("pin a enable", {8'h00, cfgs[i][7] ? 8'h00 : 8'hff}, {8'h00, oe_a});
            check("pin b data", {8'h00, exp_byte(cfgs[i] ^ 8'h60)}, {8'h00, rx_b});
            check("pin b enable", 16'h0000, {8'h00, oe_b});
        end
        $display("test slot_streams done");
        // Idle settings swapped on the last slot of each pin
        hz_a = 1'b0;
        hz_b = 1'b1;
        run_slot(31);
        check("pin a idle data", 16'h0000, {8'h00, rx_a});
        check("pin a idle enable", 16'h0000, {8'h00, oe_a});
        check("pin b idle enable", 16'h00ff, {8'h00, oe_b});
        $display("test idle_levels done");
        // Reset in mid-run clears the table and releases both pins
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check("pin a in reset", 16'h0001, {14'h0000, pin_a});
        check("pin b in reset", 16'h0001, {14'h0000, pin_b});
        check("read data in reset", 16'h0000, rdata);
        rst = 1'b0;
        reg_rd(16'hf3bf, 16'h0000);
        $display("test mid_reset done");
        summarize();
    end
endmodule
